// ---- optload_pkg.sv ----
// Package: constants for the flash option bit loader
package optload_pkg;
  // Flash program memory locations of the user option bytes
  localparam logic [15:0] OPT0_ADDR = 16'h0000;
  localparam logic [15:0] OPT1_ADDR = 16'h0001;
  // Information page base of the trim bytes (info 20..3F)
  localparam logic [15:0] TRIM_INFO_BASE = 16'hFE20;
  // Register file offsets
  localparam logic [11:0] TRIM_INDEX_OFS = 12'h0FF6;
  localparam logic [11:0] TRIM_VALUE_OFS = 12'h0FF7;
  localparam logic [11:0] PAGE_SELECT_OFS = 12'h0FF9;
  // Reset values
  localparam logic [7:0] TRIM_INDEX_RST = 8'h00;
  localparam logic [7:0] TRIM_VALUE_RST = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // Trim store geometry
  localparam int TRIM_COUNT = 32;
  localparam int TRIM_IDX_W = 5;
  // Option byte 0 field positions
  localparam int WDT_RESP_BIT = 7;
  localparam int WATCHDOG_ALWAYS_ON_BIT = 6;
  localparam int OSC_HI_BIT = 5;
  localparam int OSC_LO_BIT = 4;
  localparam int BO_AO_BIT = 3;
  localparam int READ_PROT_BIT = 2;
  localparam int WRITE_PROT_BIT = 0;
  // Option byte 1 field position
  localparam int XTAL_OFF_BIT = 4;
  // Information area enable in the page select register
  localparam int INFO_EN_BIT = 7;
  // Oscillator drive encodings
  localparam logic [1:0] OSC_RC = 2'h0;
  localparam logic [1:0] OSC_MIN = 2'h1;
  localparam logic [1:0] OSC_MED = 2'h2;
  localparam logic [1:0] OSC_MAX = 2'h3;
  // Load sequencer states
  typedef enum logic [2:0] {
    ST_FETCH0 = 3'b000,
    ST_FETCH1 = 3'b001,
    ST_TRIM = 3'b010,
    ST_DONE = 3'b011
  } load_state_e;
endpackage

// ---- flash_option_bit_loader.sv ----
// Module: reset-time option byte loader and trim byte working store

// Load sequence after any reset
// Edge 1 raises the flash read strobe at the first option byte address.
// Edge 2 takes that byte and asks for the second option byte.
// Edge 3 takes the second byte and points the flash at the first trim byte.
// Edges 4 to 35 copy the factory trim bytes into the working store.
// Edge 35 also drops the hold on the CPU reset.
//
// The flash answers one cycle after the strobe; a slower array would need
// wait states here, which this block does not provide.
//
// Register accesses are ignored while the load runs, so software can never
// race the copy of the factory trim bytes.
//
// The option bytes are read only by the load; no register address reaches
// them, which keeps the protection settings out of software's hands.
//
// The trim index keeps all eight bits for read-back, but only the low five
// pick a byte; a stray high bit therefore wraps inside the trim area
// instead of reaching other parts of the information page.
//
// Trim writes touch only the flip-flop copy; the next reset restores the
// factory bytes from flash.
//
// The crystal bit is stored already inverted, so that its output comes
// straight from a flip-flop like every other output.

`timescale 1ns/1ps
`default_nettype none
module flash_option_bit_loader (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,

  // Flash read port
  output logic [15:0] FLASH_ADDR_O,
  output logic FLASH_INFO_O,
  output logic FLASH_RD_O,
  input wire logic [7:0] FLASH_DATA_I,

  // Register file port
  input wire logic [11:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,

  // Page select register state from the flash controller
  input wire logic [7:0] PAGE_SELECT_I,

  // Reset hold toward the CPU
  output logic CPU_RESET_HOLD_O,

  // Decoded option configuration, and the information area mapping from page select
  output logic WDT_RESET_ON_TIMEOUT_O,
  output logic WDT_START_BY_INSTR_O,
  output logic [1:0] OSC_DRIVE_SELECT_O,
  output logic BROWNOUT_IN_STOP_O,
  output logic CODE_READABLE_O,
  output logic USER_FLASH_WRITE_EN_O,
  output logic CRYSTAL_ON_IN_RESET_O,
  output logic INFO_AREA_MAPPED_O,

  // Trim working copies to the analog blocks
  output logic [255:0] TRIM_BYTES_O
);

  // All state of the loader in one record
  typedef struct packed {
    // Load sequencer
    optload_pkg::load_state_e state;
    logic [4:0] trim_ptr;
    logic [15:0] faddr;
    logic finfo;
    logic frd;
    logic hold;

    // Option configuration, frozen between resets
    logic [7:0] opt0;
    logic xtal_on;

    // Register file side
    logic [7:0] trim_index;
    logic [7:0] rdata;
    logic info_map;

    // Working copies of the trim bytes
    logic [255:0] trim;
  } state_s;

  // Present and next state
  state_s cur_r;
  state_s cur_nxt;

  // Trim byte picked by the index register
  logic [4:0] sel;

  // Index decode keeps accesses inside the trim area
  assign sel = cur_r.trim_index[optload_pkg::TRIM_IDX_W-1:0];

  // Next-state: load sequencer then register file service
  always_comb begin
    // Hold everything unless a branch says otherwise
    cur_nxt = cur_r;

    // The read strobe drops unless a branch raises it again
    cur_nxt.frd = 1'b0;

    // Page select is mirrored every cycle, also during the load
    cur_nxt.info_map = PAGE_SELECT_I[optload_pkg::INFO_EN_BIT];

    case (cur_r.state)

      // First option byte
      optload_pkg::ST_FETCH0: begin
        // Flash returns data one cycle after the read strobe
        if (cur_r.frd) begin
          cur_nxt.opt0 = FLASH_DATA_I;
          cur_nxt.faddr = optload_pkg::OPT1_ADDR;
          cur_nxt.frd = 1'b1;
          cur_nxt.state = optload_pkg::ST_FETCH1;
        end else begin
          // First cycle after reset: only raise the strobe
          cur_nxt.faddr = optload_pkg::OPT0_ADDR;
          cur_nxt.frd = 1'b1;
        end
      end

      // Second option byte, then aim at the trim area
      optload_pkg::ST_FETCH1: begin
        cur_nxt.xtal_on = ~FLASH_DATA_I[optload_pkg::XTAL_OFF_BIT];
        cur_nxt.faddr = optload_pkg::TRIM_INFO_BASE;
        cur_nxt.finfo = 1'b1;
        cur_nxt.frd = 1'b1;
        cur_nxt.trim_ptr = 5'h00;
        cur_nxt.state = optload_pkg::ST_TRIM;
      end

      // Factory trim copied into the volatile working store
      optload_pkg::ST_TRIM: begin
        cur_nxt.trim[cur_r.trim_ptr*8 +: 8] = FLASH_DATA_I;
        if (cur_r.trim_ptr == 5'h1F) begin
          // Last byte taken: park the flash port and let the CPU run
          cur_nxt.finfo = 1'b0;
          cur_nxt.faddr = optload_pkg::OPT0_ADDR;
          cur_nxt.hold = 1'b0;
          cur_nxt.state = optload_pkg::ST_DONE;
        end else begin
          // Next trim byte; the pointer cannot leave the 32-byte area
          cur_nxt.trim_ptr = cur_r.trim_ptr + 5'h01;
          cur_nxt.faddr = cur_r.faddr + 16'h0001;
          cur_nxt.frd = 1'b1;
        end
      end

      // Running: option bytes frozen until the next reset
      optload_pkg::ST_DONE: begin
        // Index write; all eight bits are kept for read-back
        if (REG_WR_I && REG_ADDR_I == optload_pkg::TRIM_INDEX_OFS) begin
          cur_nxt.trim_index = REG_WDATA_I;
        end

        // Value write reaches only the working copy
        if (REG_WR_I && REG_ADDR_I == optload_pkg::TRIM_VALUE_OFS) begin
          cur_nxt.trim[sel*8 +: 8] = REG_WDATA_I;
        end

        // Read data stands one cycle, zero otherwise
        if (REG_RD_I && REG_ADDR_I == optload_pkg::TRIM_INDEX_OFS) begin
          cur_nxt.rdata = cur_r.trim_index;
        end else if (REG_RD_I && REG_ADDR_I == optload_pkg::TRIM_VALUE_OFS) begin
          cur_nxt.rdata = cur_r.trim[sel*8 +: 8];
        end else begin
          // No address leads to the option configuration
          cur_nxt.rdata = 8'h00;
        end
      end

      // Unused codes restart the load
      default: begin
        cur_nxt.state = optload_pkg::ST_FETCH0;
      end

    endcase
  end

  // State register; any reset restarts the load and holds the CPU
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      // Sequencer back to the first fetch
      cur_r.state <= optload_pkg::ST_FETCH0;
      cur_r.trim_ptr <= 5'h00;
      cur_r.faddr <= optload_pkg::OPT0_ADDR;
      cur_r.finfo <= 1'b0;
      cur_r.frd <= 1'b0;
      cur_r.hold <= 1'b1;

      // Erased defaults stand until the load replaces them
      cur_r.opt0 <= optload_pkg::ERASED_BYTE;
      cur_r.xtal_on <= 1'b0;

      // Register side cleared
      cur_r.trim_index <= optload_pkg::TRIM_INDEX_RST;
      cur_r.rdata <= optload_pkg::TRIM_VALUE_RST;
      cur_r.info_map <= 1'b0;

      // Working copies are reloaded by the sequence anyway
      cur_r.trim <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // Flash port, straight from the sequencer flip-flops
  assign FLASH_ADDR_O = cur_r.faddr;
  assign FLASH_INFO_O = cur_r.finfo;
  assign FLASH_RD_O = cur_r.frd;

  // Register file read data
  assign REG_RDATA_O = cur_r.rdata;

  // CPU stays in reset until the whole load is over
  assign CPU_RESET_HOLD_O = cur_r.hold;

  // Watchdog configuration
  assign WDT_RESET_ON_TIMEOUT_O = cur_r.opt0[optload_pkg::WDT_RESP_BIT];
  assign WDT_START_BY_INSTR_O = cur_r.opt0[optload_pkg::WATCHDOG_ALWAYS_ON_BIT];

  // Oscillator drive level
  assign OSC_DRIVE_SELECT_O = cur_r.opt0[optload_pkg::OSC_HI_BIT:optload_pkg::OSC_LO_BIT];

  // Brown-out and code protection
  assign BROWNOUT_IN_STOP_O = cur_r.opt0[optload_pkg::BO_AO_BIT];
  assign CODE_READABLE_O = cur_r.opt0[optload_pkg::READ_PROT_BIT];
  assign USER_FLASH_WRITE_EN_O = cur_r.opt0[optload_pkg::WRITE_PROT_BIT];

  // Crystal during reset; clock source choice is left to software
  assign CRYSTAL_ON_IN_RESET_O = cur_r.xtal_on;

  // Information area mapping, one cycle behind the page select register
  assign INFO_AREA_MAPPED_O = cur_r.info_map;

  // Working trim copies toward the analog blocks
  assign TRIM_BYTES_O = cur_r.trim;

endmodule // flash_option_bit_loader
`default_nettype wire

// ---- flash_model.sv ----
// Flash array model serving option and trim bytes
`timescale 1ns/1ps
`default_nettype none
module flash_model (
  input wire logic clk_i,
  input wire logic rd_i,
  input wire logic info_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] opt_i,
  output logic [7:0] data_o
);
  logic [7:0] last_r = 8'h00;
  // Idle bus shows the inverse of the last byte so stale data never passes
  always_comb begin
    if (!rd_i) data_o = ~last_r;
    else if (info_i) data_o = addr_i[7:0] ^ 8'hA5;
    else data_o = addr_i[0] ? opt_i[15:8] : opt_i[7:0];
  end
  always @(posedge clk_i) last_r <= data_o;
endmodule // flash_model
`default_nettype wire

// ---- optload_asserts.sv ----
// Port assertions for the option loader
`timescale 1ns/1ps
`default_nettype none
module optload_chk (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic [15:0] FLASH_ADDR_O,
  input wire logic FLASH_INFO_O,
  input wire logic FLASH_RD_O,
  input wire logic [7:0] FLASH_DATA_I,
  input wire logic [11:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic CPU_RESET_HOLD_O,
  input wire logic WDT_RESET_ON_TIMEOUT_O,
  input wire logic CRYSTAL_ON_IN_RESET_O,
  input wire logic [255:0] TRIM_BYTES_O
);
  logic [5:0] cnt_r;
  logic [4:0] idx_r;
  wire logic rd0 = FLASH_RD_O && !FLASH_INFO_O && FLASH_ADDR_O == 16'h0000;
  wire logic rd1 = FLASH_RD_O && !FLASH_INFO_O && FLASH_ADDR_O == 16'h0001;
  wire logic go = !CPU_RESET_HOLD_O;
  // Edges since release, saturating; index mirror ignores accesses under hold
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      cnt_r <= 6'h00;
      idx_r <= 5'h00;
    end else begin
      cnt_r <= cnt_r + {5'h00, cnt_r != 6'h3F};
      if (go && REG_WR_I && REG_ADDR_I == 12'hFF6) idx_r <= REG_WDATA_I[4:0];
    end
  end
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  sequence fetch_s;
    rd0 ##1 rd1 ##1 (FLASH_RD_O && FLASH_INFO_O);
  endsequence
  load_order_a: assert property (cnt_r == 6'h01 |-> fetch_s)
    else $error("option fetch order wrong");
  hold_span_a: assert property (CPU_RESET_HOLD_O == (cnt_r < 6'h23))
    else $error("reset hold length wrong");
  opt_take_a: assert property (rd0 |=> WDT_RESET_ON_TIMEOUT_O == $past(FLASH_DATA_I[7]))
    else $error("option byte 0 not taken");
  xtal_take_a: assert property (rd1 |=> CRYSTAL_ON_IN_RESET_O != $past(FLASH_DATA_I[4]))
    else $error("crystal bit not taken");
  opt_frozen_a: assert property (go |=> $stable({WDT_RESET_ON_TIMEOUT_O, CRYSTAL_ON_IN_RESET_O}))
    else $error("options moved outside reset");
  trim_area_a: assert property (FLASH_RD_O && FLASH_INFO_O |-> FLASH_ADDR_O[15:5] == 11'h7F1)
    else $error("trim fetch outside area");
  trim_write_a: assert property (go && REG_WR_I && REG_ADDR_I == 12'hFF7
    |=> TRIM_BYTES_O[idx_r*8+:8] == $past(REG_WDATA_I)) else $error("trim write lost");
  trim_read_a: assert property (go && REG_RD_I && REG_ADDR_I == 12'hFF7
    |=> REG_RDATA_O == $past(TRIM_BYTES_O[idx_r*8+:8])) else $error("trim read wrong");
endmodule // optload_chk
bind flash_option_bit_loader optload_chk chk_i (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .FLASH_ADDR_O(FLASH_ADDR_O),
  .FLASH_INFO_O(FLASH_INFO_O), .FLASH_RD_O(FLASH_RD_O), .FLASH_DATA_I(FLASH_DATA_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .CPU_RESET_HOLD_O(CPU_RESET_HOLD_O),
  .WDT_RESET_ON_TIMEOUT_O(WDT_RESET_ON_TIMEOUT_O),
  .CRYSTAL_ON_IN_RESET_O(CRYSTAL_ON_IN_RESET_O), .TRIM_BYTES_O(TRIM_BYTES_O));
`default_nettype wire

// ---- test_flash_option_bit_loader.sv ----
// Self-checking bench for the option loader
`timescale 1ns/1ps
`default_nettype none
module test_flash_option_bit_loader;
  logic CLOCK_I = 0, RST_I = 1, REG_WR_I = 0, REG_RD_I = 0;
  logic [11:0] REG_ADDR_I = 12'h000;
  logic [7:0] REG_WDATA_I = 8'h00, PAGE_SELECT_I = 8'h00, FLASH_DATA_I, REG_RDATA_O, rdv;
  logic [15:0] FLASH_ADDR_O, opt = 16'hFFFF;
  logic [15:0] tbl [4] = '{16'hFFFF, 16'hEF02, 16'hFFAA, 16'hEF57};
  logic [1:0] OSC_DRIVE_SELECT_O;
  logic [255:0] TRIM_BYTES_O;
  logic FLASH_INFO_O, FLASH_RD_O, CPU_RESET_HOLD_O, WDT_RESET_ON_TIMEOUT_O, WDT_START_BY_INSTR_O;
  logic BROWNOUT_IN_STOP_O, CODE_READABLE_O, USER_FLASH_WRITE_EN_O, CRYSTAL_ON_IN_RESET_O;
  logic INFO_AREA_MAPPED_O;
  logic [31:0] seed = 32'h0000_47C4;
  int n_mismatch = 0, compares = 0;
  wire logic [7:0] opt_got = {WDT_RESET_ON_TIMEOUT_O, WDT_START_BY_INSTR_O, OSC_DRIVE_SELECT_O,
    BROWNOUT_IN_STOP_O, CODE_READABLE_O, USER_FLASH_WRITE_EN_O, CRYSTAL_ON_IN_RESET_O};
  flash_option_bit_loader uut (.*);
  flash_model fm (.clk_i(CLOCK_I), .rd_i(FLASH_RD_O), .info_i(FLASH_INFO_O),
    .addr_i(FLASH_ADDR_O), .opt_i(opt), .data_o(FLASH_DATA_I));
  initial forever #25 CLOCK_I = ~CLOCK_I;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Decoded option outputs: byte 0 fields, then the inverted crystal bit of byte 1
  function automatic logic [7:0] opt_exp(input logic [15:0] o);
    return {o[7:2], o[0], ~o[12]};
  endfunction
  function automatic logic [255:0] trim_exp();
    logic [255:0] t;
    for (int i = 0; i < 32; i++) t[8*i+:8] = 8'(i + 32) ^ 8'hA5;
    return t;
  endfunction
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // One register access; read data is taken mid-cycle, after it has settled
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    REG_ADDR_I <= a;
    REG_WDATA_I <= d;
    REG_WR_I <= w;
    REG_RD_I <= !w;
    @(posedge CLOCK_I);
    REG_WR_I <= 0;
    REG_RD_I <= 0;
    @(negedge CLOCK_I);
    rdv = REG_RDATA_O;
    @(posedge CLOCK_I);
  endtask
  task automatic do_reset();
    RST_I <= 1;
    repeat (3) @(posedge CLOCK_I);
    RST_I <= 0;
    for (int i = 0; i < 40 && CPU_RESET_HOLD_O !== 1'b0; i++) @(negedge CLOCK_I);
    chk(CPU_RESET_HOLD_O, 1'b0);
  endtask
  task automatic results();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
  // Every round reloads new option bytes, then exercises the trim registers
  initial begin
    for (int r = 0; r < 6; r++) begin
      opt <= (r < 4) ? tbl[r] : (seed[15:0] | 16'hEF02);
      do_reset();
      chk(opt_got, opt_exp(opt));
      chk(TRIM_BYTES_O, trim_exp());
      @(posedge CLOCK_I);
      opt <= ~opt;
      for (int k = 0; k < 4; k++) begin
        seed = xs(seed);
        PAGE_SELECT_I <= seed[31:24];
        acc(1, 12'hFF6, seed[7:0]);
        acc(1, 12'hFF7, seed[15:8]);
        chk(TRIM_BYTES_O[seed[4:0]*8+:8], seed[15:8]);
        acc(0, 12'hFF7, 8'h00);
        chk(rdv, seed[15:8]);
        acc(0, 12'hFF6, 8'h00);
        chk(rdv, seed[7:0]);
        acc(0, 12'hFF5, 8'h00);
        chk(rdv, 8'h00);
        chk(INFO_AREA_MAPPED_O, seed[31]);
        chk(opt_got, opt_exp(~opt));
      end
    end
    results();
  end
endmodule // test_flash_option_bit_loader
`default_nettype wire
